/* slsf_asserts.sv */
// assertion checker for the status flag register bank
module slsf_asserts
	import slsf_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [11:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        pll_locked,
	input wire logic        cal_done,
	input wire logic        sample_clock_input
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_rd;
		s_axi_arvalid && s_axi_arready && s_axi_araddr == SLSF_STATUS_OFFSET;
	endsequence
	property p_live;
		s_rd |=> s_axi_rdata[2:0] == $past({pll_locked, cal_done, sample_clock_input});
	endproperty
	a_live: assert property (p_live) else $error("live bits wrong");
	property p_lost;
		s_rd ##0 !$past(sample_clock_input) |=> s_axi_rdata[4:3] == 2'h0;
	endproperty
	a_lost: assert property (p_lost) else $error("sticky kept");
	property p_link;
		s_rd ##1 s_axi_rdata[6] |-> s_axi_rdata[5];
	endproperty
	a_link: assert property (p_link) else $error("link up in sync");
	property p_hi;
		s_axi_rvalid |-> s_axi_rdata[31:7] == 25'h0;
	endproperty
	a_hi: assert property (p_hi) else $error("high bits set");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read dropped");
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_bhold: assert property (p_bhold) else $error("resp dropped");
	property p_rlat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rlat: assert property (p_rlat) else $error("read late");
	property p_arr;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_arr: assert property (p_arr) else $error("second read");
endmodule
bind slsf_top slsf_asserts i_slsf_asserts (.*);

/* slsf_partner.sv */
// link receiver model: frame ticks and a held sync request
module slsf_partner
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic req,
	output logic      frame_tick,
	output logic      sync_req_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] div_q;
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			div_q      <= 2'h0;
			frame_tick <= 1'h0;
			sync_req_n <= 1'h1;
		end
		else
		begin
			div_q      <= div_q + 2'h1;
			frame_tick <= div_q == 2'h3;
			sync_req_n <= !req;
		end
	end
endmodule

/* slsf_pkg.sv */
// constants and types for the serial link status flags block
package slsf_pkg;
	localparam logic [11:0] SLSF_STATUS_OFFSET = 12'h06c;
	localparam logic [11:0] SLSF_CTRL_OFFSET   = 12'h070;
	localparam int          SLSF_LINK_BIT      = 6;
	localparam int          SLSF_SYNC_BIT      = 5;
	localparam int          SLSF_SHIFT_BIT     = 4;
	localparam int          SLSF_ALIGN_BIT     = 3;
	localparam int          SLSF_LOCK_BIT      = 2;
	localparam int          SLSF_TRIM_BIT      = 1;
	localparam int          SLSF_CLK_BIT       = 0;
	localparam logic [2:0]  SLSF_REQ_FRAMES    = 3'h4;
	localparam logic [1:0]  SLSF_RESP_OKAY     = 2'h0;
	localparam logic [1:0]  SLSF_RESP_SLVERR   = 2'h2;
	localparam logic        SLSF_DETECT_RESET  = 1'h0;
	typedef enum logic [1:0]
	{
		SLSF_IDLE = 2'b00,
		SLSF_WAIT = 2'b01,
		SLSF_LANE = 2'b10,
		SLSF_DATA = 2'b11
	} slsf_sync_type;
endpackage

/* slsf_sticky.sv */
// one sticky status flag: hardware set wins over software clear
module slsf_sticky
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic set_evt,
	input  wire logic sw_clear,
	input  wire logic hw_clear,
	output logic      flag
);
	logic flag_q;
	logic flag_d;

	always_comb
	begin
		flag_d = flag_q;
		if (sw_clear || hw_clear)
			flag_d = 1'b0;
		// set wins over software clear; clock loss beats all
		if (set_evt && !hw_clear)
			flag_d = 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			flag_q <= 1'b0;
		else
			flag_q <= flag_d;
	end

	assign flag = flag_q;
endmodule

/* slsf_sync_fsm.sv */
// synchronisation state machine that drives link-up and request-idle flags
module slsf_sync_fsm
	import slsf_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic frame_tick,
	input  wire logic sync_req_n,
	input  wire logic lane_align_done,
	input  wire logic data_valid,
	output logic      link_up,
	output logic      req_idle
);
	slsf_sync_type state_q;
	slsf_sync_type state_d;
	logic [2:0]    cnt_q;
	logic [2:0]    cnt_d;

	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q;
		case (state_q)
			SLSF_IDLE:
			begin
				// count request frames; shorter pulses ignored
				if (sync_req_n)
					cnt_d = 3'h0;
				else if (frame_tick && cnt_q != SLSF_REQ_FRAMES)
					cnt_d = cnt_q + 3'h1;
				// request dropped before it qualified: link was never torn down
				if (sync_req_n)
					state_d = SLSF_DATA;
				else if (cnt_q == SLSF_REQ_FRAMES)
					state_d = SLSF_WAIT;
			end
			SLSF_WAIT:
			begin
				cnt_d = 3'h0;
				if (sync_req_n)
					state_d = SLSF_LANE;
			end
			SLSF_LANE:
			begin
				if (!sync_req_n)
					state_d = SLSF_WAIT;
				else if (lane_align_done)
					state_d = SLSF_DATA;
			end
			SLSF_DATA:
			begin
				if (!sync_req_n)
					state_d = SLSF_IDLE;
			end
			default:
				state_d = SLSF_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_q <= SLSF_DATA;
			cnt_q   <= 3'h0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// flag from state, not from the pin
	assign req_idle = (state_q != SLSF_WAIT);
	// link still up while a request is only being qualified
	assign link_up  = (state_q == SLSF_DATA || state_q == SLSF_IDLE) && data_valid;
endmodule

/* slsf_top.sv */
// serial link status register bank with an axi4-lite slave
module slsf_top
	import slsf_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        frame_tick,
	input  wire logic        sync_req_n,
	input  wire logic        lane_align_done,
	input  wire logic        data_valid,
	input  wire logic        sysref_rise,
	input  wire logic        sysref_phase_moved,
	input  wire logic        pll_locked,
	input  wire logic        cal_done,
	input  wire logic        sample_clock_input,
	output logic             sysref_detect_enable
);
	logic        aw_held_q;
	logic        aw_held_d;
	logic [11:0] aw_addr_q;
	logic [11:0] aw_addr_d;
	logic        w_held_q;
	logic        w_held_d;
	logic [31:0] w_data_q;
	logic [31:0] w_data_d;
	logic        w_strb0_q;
	logic        w_strb0_d;
	logic        bvalid_q;
	logic        bvalid_d;
	logic [1:0]  bresp_q;
	logic [1:0]  bresp_d;
	logic        rvalid_q;
	logic        rvalid_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [1:0]  rresp_q;
	logic [1:0]  rresp_d;
	logic        detect_q;
	logic        detect_d;
	logic        link_up;
	logic        req_idle;
	logic        shift_flag;
	logic        align_flag;
	logic        wr_fire;
	logic        clr_shift;
	logic        clr_align;
	logic        clk_lost;
	logic [7:0]  status;

	slsf_sync_fsm u_sync
	(
		.clk             (clk),
		.rst             (rst),
		.frame_tick      (frame_tick),
		.sync_req_n      (sync_req_n),
		.lane_align_done (lane_align_done),
		.data_valid      (data_valid),
		.link_up         (link_up),
		.req_idle        (req_idle)
	);

	// sticky flags only reach low byte lane
	assign wr_fire   = aw_held_q && w_held_q && !bvalid_q;
	assign clr_shift = wr_fire && aw_addr_q == SLSF_STATUS_OFFSET && w_strb0_q
	                   && w_data_q[SLSF_SHIFT_BIT];
	assign clr_align = wr_fire && aw_addr_q == SLSF_STATUS_OFFSET && w_strb0_q
	                   && w_data_q[SLSF_ALIGN_BIT];
	assign clk_lost  = !sample_clock_input;

	slsf_sticky u_shift
	(
		.clk      (clk),
		.rst      (rst),
		.set_evt  (sysref_phase_moved),
		.sw_clear (clr_shift),
		.hw_clear (clk_lost),
		.flag     (shift_flag)
	);

	slsf_sticky u_align
	(
		.clk      (clk),
		.rst      (rst),
		.set_evt  (sysref_rise),
		.sw_clear (clr_align),
		.hw_clear (clk_lost),
		.flag     (align_flag)
	);

	always_comb
	begin
		status                 = 8'h00;
		status[SLSF_LINK_BIT]  = link_up;
		status[SLSF_SYNC_BIT]  = req_idle;
		status[SLSF_SHIFT_BIT] = shift_flag;
		status[SLSF_ALIGN_BIT] = align_flag;
		status[SLSF_LOCK_BIT]  = pll_locked;
		status[SLSF_TRIM_BIT]  = cal_done;
		status[SLSF_CLK_BIT]   = sample_clock_input;
	end

	always_comb
	begin
		aw_held_d = aw_held_q;
		aw_addr_d = aw_addr_q;
		w_held_d  = w_held_q;
		w_data_d  = w_data_q;
		w_strb0_d = w_strb0_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		detect_d  = detect_q;
		if (s_axi_awvalid && !aw_held_q)
		begin
			aw_held_d = 1'b1;
			aw_addr_d = {s_axi_awaddr[11:2], 2'b00};
		end
		if (s_axi_wvalid && !w_held_q)
		begin
			w_held_d  = 1'b1;
			w_data_d  = s_axi_wdata;
			w_strb0_d = s_axi_wstrb[0];
		end
		if (wr_fire)
		begin
			aw_held_d = 1'b0;
			w_held_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = SLSF_RESP_OKAY;
			if (aw_addr_q == SLSF_CTRL_OFFSET)
			begin
				// hardware does not block early enable; software must poll trim flag
				if (w_strb0_q)
					detect_d = w_data_q[0];
			end
			else if (aw_addr_q != SLSF_STATUS_OFFSET)
				bresp_d = SLSF_RESP_SLVERR;
		end
		if (bvalid_q && s_axi_bready)
			bvalid_d = 1'b0;
	end

	always_comb
	begin
		rvalid_d = rvalid_q;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		if (s_axi_arvalid && !rvalid_q)
		begin
			rvalid_d = 1'b1;
			rresp_d  = SLSF_RESP_OKAY;
			rdata_d  = 32'h0000_0000;
			case ({s_axi_araddr[11:2], 2'b00})
				SLSF_STATUS_OFFSET: rdata_d = {24'h00_0000, status};
				SLSF_CTRL_OFFSET:   rdata_d = {31'h0000_0000, detect_q};
				default:            rresp_d = SLSF_RESP_SLVERR;
			endcase
		end
		else if (rvalid_q && s_axi_rready)
			rvalid_d = 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			aw_held_q <= 1'b0;
			aw_addr_q <= 12'h000;
			w_held_q  <= 1'b0;
			w_data_q  <= 32'h0000_0000;
			w_strb0_q <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= SLSF_RESP_OKAY;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= SLSF_RESP_OKAY;
			detect_q  <= SLSF_DETECT_RESET;
		end
		else
		begin
			aw_held_q <= aw_held_d;
			aw_addr_q <= aw_addr_d;
			w_held_q  <= w_held_d;
			w_data_q  <= w_data_d;
			w_strb0_q <= w_strb0_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
			detect_q  <= detect_d;
		end
	end

	// ready comes from the holding flags and rvalid_q so it is a flop output
	assign s_axi_awready        = !aw_held_q;
	assign s_axi_wready         = !w_held_q;
	assign s_axi_bvalid         = bvalid_q;
	assign s_axi_bresp          = bresp_q;
	assign s_axi_arready        = !rvalid_q;
	assign s_axi_rvalid         = rvalid_q;
	assign s_axi_rdata          = rdata_q;
	assign s_axi_rresp          = rresp_q;
	assign sysref_detect_enable = detect_q;
endmodule

/* tb_top.sv */
// self-checking bench for the status flag register bank
module tb_top
	import slsf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'h0, rst = 1'h1, req = 1'h0;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, frame_tick, sync_req_n;
	logic        sysref_rise = 1'h0, sysref_phase_moved = 1'h0, lane_align_done = 1'h0;
	logic        data_valid = 1'h1, pll_locked = 1'h1, cal_done = 1'h1;
	logic        sample_clock_input = 1'h1, sysref_detect_enable;
	int          error_cnt = 0, comparisons = 0;
	slsf_top i_slsf_top (.*);
	slsf_partner i_slsf_partner (.*);
	initial
	begin
		forever #12.5 clk = !clk;
	end
	task automatic close_out;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic guard(input int n);
		if (n >= 40)
		begin
			error_cnt++;
			close_out;
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(posedge clk);
			n++;
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end
		while (!s_axi_bvalid && n < 40);
		rr = s_axi_bresp;
		s_axi_bready <= 1'h0;
		guard(n);
	endtask
	task automatic rd(input logic [11:0] a);
		int n;
		n = 0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do
		begin
			@(posedge clk);
			n++;
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end
		while (!s_axi_rvalid && n < 40);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'h0;
		guard(n);
	endtask
	task automatic cs(input logic [3:0] hi);
		rd(SLSF_STATUS_OFFSET);
		chk("status", {25'h0, hi, pll_locked, cal_done, sample_clock_input}, rv);
	endtask
	task automatic ev(input logic r, input logic m);
		sysref_rise <= r;
		sysref_phase_moved <= m;
		@(posedge clk);
		sysref_rise <= 1'h0;
		sysref_phase_moved <= 1'h0;
	endtask
	task automatic t_live;
		for (int i = 0; i < 8; i++)
		begin
			{pll_locked, cal_done, sample_clock_input} <= i[2:0];
			cs(4'hc);
		end
	endtask
	task automatic t_sticky;
		ev(1'h1, 1'h0);
		cs(4'hd);
		ev(1'h1, 1'h1);
		cs(4'hf);
		wr(SLSF_STATUS_OFFSET, 32'h0000_00e7);
		chk("bresp", {30'h0, SLSF_RESP_OKAY}, {30'h0, rr});
		cs(4'hf);
		wr(SLSF_STATUS_OFFSET, 32'h0000_0010);
		cs(4'hd);
		wr(SLSF_STATUS_OFFSET, 32'h0000_0008);
		cs(4'hc);
		ev(1'h1, 1'h1);
		sample_clock_input <= 1'h0;
		cs(4'hc);
		sample_clock_input <= 1'h1;
		cs(4'hc);
	endtask
	task automatic t_sync;
		req <= 1'h1;
		repeat (4) @(posedge clk);
		cs(4'hc);
		req <= 1'h0;
		repeat (4) @(posedge clk);
		cs(4'hc);
		req <= 1'h1;
		repeat (40) @(posedge clk);
		cs(4'h0);
		req <= 1'h0;
		repeat (8) @(posedge clk);
		cs(4'h4);
		lane_align_done <= 1'h1;
		@(posedge clk);
		lane_align_done <= 1'h0;
		cs(4'hc);
		data_valid <= 1'h0;
		cs(4'h4);
		data_valid <= 1'h1;
	endtask
	task automatic t_ctrl;
		int n;
		n = 0;
		cal_done <= 1'h0;
		do
		begin
			rd(SLSF_STATUS_OFFSET);
			n++;
			if (n == 3)
				cal_done <= 1'h1;
		end
		while (!rv[SLSF_TRIM_BIT] && n < 40);
		chk("polls", 32'h0000_0004, n);
		wr(SLSF_CTRL_OFFSET, 32'h0000_0001);
		rd(SLSF_CTRL_OFFSET);
		chk("ctrl", 32'h0000_0001, rv);
		chk("detect", 32'h0000_0001, {31'h0, sysref_detect_enable});
		wr(12'h0f0, 32'h0000_0001);
		chk("bresp", {30'h0, SLSF_RESP_SLVERR}, {30'h0, rr});
		rd(12'h0f0);
		chk("rresp", {30'h0, SLSF_RESP_SLVERR}, {30'h0, rr});
	endtask
	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'h0;
		cs(4'hc);
		chk("detect", 32'h0, {31'h0, sysref_detect_enable});
		t_live;
		t_sticky;
		t_sync;
		t_ctrl;
		close_out;
	end
endmodule
